// ---- common/alu_slice_pkg.sv ----
package alu_slice_pkg;
   // ************************************************************
   // Field positions of the instruction word
   // ************************************************************
   localparam int OPC_HI = 31;
   localparam int OPC_LO = 26;
   localparam int SRCA_HI = 25;
   localparam int SRCA_LO = 21;
   localparam int SRCB_HI = 20;
   localparam int SRCB_LO = 16;
   localparam int DEST_HI = 15;
   localparam int DEST_LO = 11;
   localparam int SHAMT_HI = 10;
   localparam int SHAMT_LO = 6;
   localparam int FUNC_HI = 5;
   localparam int FUNC_LO = 0;
   localparam int SPIN_FIXED_BIT = 21;
   localparam int SPIN_VAR_BIT = 6;

   // ************************************************************
   // Encodings
   // ************************************************************
   localparam logic [5:0] OPC_SPECIAL = 6'h00;
   localparam logic [5:0] FN_LEFT_LOGICAL = 6'h00;
   localparam logic [5:0] FN_RIGHT_LOGICAL_FIXED = 6'h02;
   localparam logic [5:0] FN_RIGHT_LOGICAL_VAR = 6'h06;
   localparam logic [5:0] FN_RIGHT_ARITH_VAR = 6'h07;
   localparam logic [5:0] FN_MINUS_TRAP = 6'h22;
   localparam logic [5:0] FN_MINUS_WRAP = 6'h23;
   localparam logic [4:0] IDLE_SHAMT = 5'h01;
   localparam logic [4:0] REG_ZERO = 5'h00;

   // ************************************************************
   // Widths and reset values
   // ************************************************************
   localparam int WORD_W = 32;
   localparam int COUNT_W = 5;
   localparam logic [63:0] RESULT_RST = 64'h0000000000000000;
   localparam logic [4:0] DEST_RST = 5'h00;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_RIGHT_ARITH_VAR,
      OP_RIGHT_LOGICAL_FIXED,
      OP_RIGHT_LOGICAL_VAR,
      OP_SUB_TRAP,
      OP_SUB_WRAP,
      OP_IDLE
   } alu_op_e;
endpackage

// ---- hw/int_shift_subtract_alu.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Arith var right shift: opcode 000000, function 000111, bits 10..6 zero.
// - Arith right shift fills with bit 31, word result sign-extended to 64 bits.
// - Variable shifts use only low five bits of source_a as count.
// - Fixed logical right shift: opcode zero, bits 25..22 zero, bit 21 clear.
// - Logical right shifts zero fill, word result sign-extended to 64 bits.
// - Var logical right shift: function 000110, bits 10..7 zero, bit 6 clear.
// - Idle issue-break: left shift, register zero both ends, amount 00001.
// - Multi-issue: end group before idle instruction, issue it alone.
// - Single-issue: idle instruction is a no-op taking one slot.
// - Release 6: idle instruction may act as a plain no-op.
// - Next instruction issues no earlier than cycle after idle; no extra delay.
// - Trapping subtract: function 100010, bits 10..6 zero, source_a minus source_b.
// - 33-bit difference; bit 32 differs from 31 gives overflow, no write.
// - No overflow: write sign-extended low 32 bits of difference.
// - Wrapping subtract: function 100011, modulo result, never overflow.
module int_shift_subtract_alu
   import alu_slice_pkg::*;
#(
   parameter int DATA_W = 64,
   parameter bit MULTI_ISSUE = 1'b1,
   parameter bit RELEASE6 = 1'b0
) (
   input wire logic ref_clk_i, // Core clock
   input wire logic nrst_i, // Async reset, active low
   input wire logic issue_valid_i, // Instruction presented this cycle
   input wire logic [31:0] instr_i, // Instruction word
   input wire logic [DATA_W-1:0] src_a_i, // Value of source_a register
   input wire logic [DATA_W-1:0] src_b_i, // Value of source_b register
   output logic [DATA_W-1:0] result_o, // Result to destination
   output logic [4:0] dest_o, // Destination register index
   output logic wr_en_o, // Destination write enable pulse
   output logic overflow_o, // Integer overflow exception pulse
   output logic accepted_o, // Instruction recognised by this slice
   output logic issue_break_o, // Close issue group, next slot solo
   output logic solo_issue_o // Idle instruction issues alone
);
   // ************************************************************
   // Parameter checks
   // ************************************************************
   // Narrower data would cut the word itself
   initial begin
      if (DATA_W < WORD_W) begin
         $error("int_shift_subtract_alu needs DATA_W of at least 32");
      end
      if ((1 << COUNT_W) != WORD_W) begin
         $error("int_shift_subtract_alu needs a count that spans the word");
      end
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   // Sign-extends a word into the full data width
   function automatic logic [DATA_W-1:0] sext_word(input logic [WORD_W-1:0] w);
      return {{(DATA_W-WORD_W){w[WORD_W-1]}}, w};
   endfunction

   // ************************************************************
   // Decode
   // ************************************************************
   function automatic alu_op_e decode_op(input logic [31:0] ins);
      alu_op_e op;
      logic special;
      op = OP_NONE;
      special = (ins[OPC_HI:OPC_LO] == OPC_SPECIAL);
      if (special) begin
         unique case (ins[FUNC_HI:FUNC_LO])
            FN_RIGHT_ARITH_VAR: begin
               if (ins[SHAMT_HI:SHAMT_LO] == 5'h00) op = OP_RIGHT_ARITH_VAR;
            end
            FN_RIGHT_LOGICAL_FIXED: begin
               if (ins[SRCA_HI:SPIN_FIXED_BIT] == 5'h00) op = OP_RIGHT_LOGICAL_FIXED;
            end
            FN_RIGHT_LOGICAL_VAR: begin
               if (ins[SHAMT_HI:SPIN_VAR_BIT] == 5'h00) op = OP_RIGHT_LOGICAL_VAR;
            end
            FN_MINUS_TRAP: begin
               if (ins[SHAMT_HI:SHAMT_LO] == 5'h00) op = OP_SUB_TRAP;
            end
            FN_MINUS_WRAP: begin
               if (ins[SHAMT_HI:SHAMT_LO] == 5'h00) op = OP_SUB_WRAP;
            end
            // Only shift-by-one with all register fields zero; the plain no-op is not ours
            FN_LEFT_LOGICAL: begin
               if (ins[SRCA_HI:SRCA_LO] == REG_ZERO && ins[SRCB_HI:SRCB_LO] == REG_ZERO &&
                   ins[DEST_HI:DEST_LO] == REG_ZERO &&
                   ins[SHAMT_HI:SHAMT_LO] == IDLE_SHAMT) op = OP_IDLE;
            end
            default: op = OP_NONE;
         endcase
      end
      return op;
   endfunction

   alu_op_e op;
   logic [COUNT_W-1:0] shift_count;
   logic arith;
   logic [DATA_W-1:0] shift_res;
   logic [WORD_W:0] diff;
   logic ovf;

   always_comb begin
      op = issue_valid_i ? decode_op(instr_i) : OP_NONE;
      // Only the low five bits of source_a count; upper bits are ignored
      shift_count = (op == OP_RIGHT_LOGICAL_FIXED) ? instr_i[SHAMT_HI:SHAMT_LO]
                                                   : src_a_i[COUNT_W-1:0];
      arith = (op == OP_RIGHT_ARITH_VAR);
   end

   // ************************************************************
   // Subtractor
   // ************************************************************
   // Operands are assumed sign-extended words; bits above 31 are not checked
   always_comb begin
      diff = {src_a_i[WORD_W-1], src_a_i[WORD_W-1:0]}
             - {src_b_i[WORD_W-1], src_b_i[WORD_W-1:0]};
      ovf = diff[WORD_W] != diff[WORD_W-1];
   end

   // ************************************************************
   // Shifter
   // ************************************************************
   // One shifter serves all three shifts; the fixed count comes from the word
   word_shifter #(
      .DATA_W(DATA_W)
   ) u_shifter (
      .src_i(src_b_i),
      .count_i(shift_count),
      .arith_i(arith),
      .result_o(shift_res)
   );

   // ************************************************************
   // Result stage
   // ************************************************************
   // Result holds between writes, index also moves on an overflowing trapping subtract; the pulses last one cycle
   logic [DATA_W-1:0] result_ff, nxt_result;
   logic [4:0] dest_ff, nxt_dest;
   logic wr_en_ff, nxt_wr_en;
   logic overflow_ff, nxt_overflow;
   logic accepted_ff, nxt_accepted;
   logic issue_break_ff, nxt_issue_break;
   logic solo_ff, nxt_solo;

   always_comb begin
      nxt_result = result_ff;
      nxt_dest = dest_ff;
      nxt_wr_en = 1'b0;
      nxt_overflow = 1'b0;
      nxt_accepted = op != OP_NONE;
      nxt_issue_break = 1'b0;
      nxt_solo = 1'b0;
      unique case (op)
         OP_RIGHT_ARITH_VAR, OP_RIGHT_LOGICAL_FIXED, OP_RIGHT_LOGICAL_VAR: begin
            nxt_result = shift_res;
            nxt_dest = instr_i[DEST_HI:DEST_LO];
            nxt_wr_en = 1'b1;
         end
         OP_SUB_TRAP: begin
            // Index still moves so the exception logic can name the target
            nxt_dest = instr_i[DEST_HI:DEST_LO];
            if (ovf) begin
               // Exception and write suppression share one cycle
               nxt_overflow = 1'b1;
            end else begin
               nxt_result = sext_word(diff[WORD_W-1:0]);
               nxt_wr_en = 1'b1;
            end
         end
         OP_SUB_WRAP: begin
            nxt_result = sext_word(diff[WORD_W-1:0]);
            nxt_dest = instr_i[DEST_HI:DEST_LO];
            nxt_wr_en = 1'b1;
         end
         OP_IDLE: begin
            // No write: takes a slot and changes no state
            // Release 6 idles are plain no-ops, so both flags stay low
            nxt_issue_break = MULTI_ISSUE && !RELEASE6;
            nxt_solo = MULTI_ISSUE && !RELEASE6;
         end
         OP_NONE: begin
         end
      endcase
   end

   // Single-cycle break: the next slot is free again, no added delay
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         result_ff <= DATA_W'(RESULT_RST);
         dest_ff <= DEST_RST;
         wr_en_ff <= 1'b0;
         overflow_ff <= 1'b0;
         accepted_ff <= 1'b0;
         issue_break_ff <= 1'b0;
         solo_ff <= 1'b0;
      end else begin
         result_ff <= nxt_result;
         dest_ff <= nxt_dest;
         wr_en_ff <= nxt_wr_en;
         overflow_ff <= nxt_overflow;
         accepted_ff <= nxt_accepted;
         issue_break_ff <= nxt_issue_break;
         solo_ff <= nxt_solo;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign result_o = result_ff;
   assign dest_o = dest_ff;
   assign wr_en_o = wr_en_ff;
   assign overflow_o = overflow_ff;
   assign accepted_o = accepted_ff;
   assign issue_break_o = issue_break_ff;
   assign solo_issue_o = solo_ff;
endmodule

// ---- hw/word_shifter.sv ----
`timescale 1ns/1ps
// Combinational 32-bit right shifter, result sign-extended to the data width
module word_shifter
   import alu_slice_pkg::*;
#(
   parameter int DATA_W = 64
) (
   input wire logic [DATA_W-1:0] src_i, // Operand whose low word is shifted
   input wire logic [COUNT_W-1:0] count_i, // Shift count
   input wire logic arith_i, // High: fill with bit 31
   output logic [DATA_W-1:0] result_o // Sign-extended word result
);
   initial begin
      if (DATA_W < WORD_W) begin
         $error("word_shifter needs DATA_W of at least 32");
      end
   end

   logic [WORD_W-1:0] word;
   logic fill;

   always_comb begin
      fill = arith_i & src_i[WORD_W-1];
      word = WORD_W'({{WORD_W{fill}}, src_i[WORD_W-1:0]} >> count_i);
      result_o = {{(DATA_W-WORD_W){word[WORD_W-1]}}, word};
   end
endmodule

// ---- verification/alu_slice_assertions.sv ----
`timescale 1ns/1ps
module alu_slice_checker
   import alu_slice_pkg::*;
#(
   parameter int DATA_W = 64,
   parameter bit MULTI_ISSUE = 1'b1,
   parameter bit RELEASE6 = 1'b0
) (
   input wire logic ref_clk_i, // Core clock
   input wire logic nrst_i, // Async reset, active low
   input wire logic issue_valid_i, // Instruction presented
   input wire logic [31:0] instr_i, // Instruction word
   input wire logic [DATA_W-1:0] src_a_i, // source_a value
   input wire logic [DATA_W-1:0] src_b_i, // source_b value
   input wire logic [DATA_W-1:0] result_o, // Result
   input wire logic [4:0] dest_o, // Destination index
   input wire logic wr_en_o, // Write enable
   input wire logic overflow_o, // Overflow pulse
   input wire logic accepted_o, // Recognised pulse
   input wire logic issue_break_o, // Issue break pulse
   input wire logic solo_issue_o // Solo issue pulse
);
   // ************************************************************
   // Reference decode and arithmetic
   // ************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   wire sp = issue_valid_i && instr_i[31:26] == OPC_SPECIAL;
   wire z106 = instr_i[10:6] == 5'h00;
   wire rav_dec = sp && instr_i[5:0] == FN_RIGHT_ARITH_VAR && z106;
   wire idle = issue_valid_i && instr_i == 32'h00000040;
   wire [32:0] diff = {src_a_i[31], src_a_i[31:0]} - {src_b_i[31], src_b_i[31:0]};
   wire [31:0] w_sra = $signed(src_b_i[31:0]) >>> src_a_i[4:0];
   wire [31:0] w_lsr = src_b_i[31:0] >> src_a_i[4:0];
   wire [31:0] w_srf = src_b_i[31:0] >> instr_i[10:6];
   sequence trap_taken;
      ##1 overflow_o && !wr_en_o && accepted_o;
   endsequence
   sequence idle_answer;
      accepted_o && !wr_en_o && !overflow_o;
   endsequence
   sub_ovf_a: assert property (sp && instr_i[5:0] == FN_MINUS_TRAP && z106 &&
      diff[32] != diff[31] |-> trap_taken ##0 dest_o == $past(instr_i[15:11]))
      else $error("trap missing");
   sub_ok_a: assert property (sp && instr_i[5:0] == FN_MINUS_TRAP && z106 &&
      diff[32] == diff[31] |=> wr_en_o && !overflow_o
      && result_o == {{32{$past(diff[31])}}, $past(diff[31:0])}) else $error("bad difference");
   wrap_sub_a: assert property (sp && instr_i[5:0] == FN_MINUS_WRAP && z106 |=>
      wr_en_o && !overflow_o && result_o == {{32{$past(diff[31])}}, $past(diff[31:0])})
      else $error("bad wrapping difference");
   arith_shift_a: assert property (rav_dec |=> wr_en_o &&
      result_o == {{32{$past(w_sra[31])}}, $past(w_sra)}) else $error("bad arith shift");
   var_logical_a: assert property (sp && instr_i[5:0] == FN_RIGHT_LOGICAL_VAR && z106 |=>
      wr_en_o && result_o == {{32{$past(w_lsr[31])}}, $past(w_lsr)}) else $error("bad shift");
   fixed_logical_a: assert property (sp && instr_i[5:0] == FN_RIGHT_LOGICAL_FIXED
      && instr_i[25:21] == 5'h00 |=> wr_en_o
      && result_o == {{32{$past(w_srf[31])}}, $past(w_srf)}) else $error("bad fixed shift");
   idle_break_a: assert property (idle |=> idle_answer ##0
      issue_break_o == (MULTI_ISSUE && !RELEASE6) && solo_issue_o == issue_break_o)
      else $error("bad idle handling");
   after_idle_a: assert property (issue_break_o && rav_dec |=> accepted_o && wr_en_o)
      else $error("issue after idle delayed");
   refuse_code_a: assert property (sp && instr_i[5:0] == FN_RIGHT_ARITH_VAR && !z106 |=>
      !accepted_o && !wr_en_o) else $error("bad encoding accepted");
endmodule
bind int_shift_subtract_alu alu_slice_checker #(.DATA_W(DATA_W), .MULTI_ISSUE(MULTI_ISSUE),
   .RELEASE6(RELEASE6)) i_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
   .issue_valid_i(issue_valid_i), .instr_i(instr_i), .src_a_i(src_a_i), .src_b_i(src_b_i),
   .result_o(result_o), .dest_o(dest_o), .wr_en_o(wr_en_o), .overflow_o(overflow_o),
   .accepted_o(accepted_o), .issue_break_o(issue_break_o), .solo_issue_o(solo_issue_o));

// ---- verification/issue_feeder.sv ----
`timescale 1ns/1ps
module issue_feeder (
   input wire logic req_i, // Issue request
   input wire logic [31:0] word_i, // Instruction to issue
   input wire logic [31:0] a_i, // source_a word
   input wire logic [31:0] b_i, // source_b word
   output logic issue_valid_o, // Instruction valid
   output logic [31:0] instr_o, // Instruction word
   output logic [63:0] src_a_o, // Sign-extended source_a
   output logic [63:0] src_b_o // Sign-extended source_b
);
   // ************************************************************
   // Operands always leave as proper word values
   // ************************************************************
   assign issue_valid_o = req_i;
   // Idle bus shows the inverse so stale values never look valid
   assign instr_o = req_i ? word_i : ~word_i;
   assign src_a_o = {{32{a_i[31]}}, a_i};
   assign src_b_o = {{32{b_i[31]}}, b_i};
endmodule

// ---- verification/tb_int_shift_subtract_alu.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module tb_int_shift_subtract_alu;
   import alu_slice_pkg::*;
   logic ref_clk_i = 1'b0, nrst_i = 1'b0, req = 1'b0;
   logic [31:0] word = 32'h0, a_w = 32'h0, b_w = 32'h0;
   wire issue_valid, wr_en, ovf, acc, brk, solo;
   wire acc6, brk6, solo6;
   wire [31:0] instr;
   wire [63:0] src_a, src_b, result;
   wire [4:0] dest;
   int err_total = 0, n_checks = 0;
   issue_feeder i_feed (.req_i(req), .word_i(word), .a_i(a_w), .b_i(b_w),
      .issue_valid_o(issue_valid), .instr_o(instr), .src_a_o(src_a), .src_b_o(src_b));
   int_shift_subtract_alu i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .issue_valid_i(issue_valid), .instr_i(instr), .src_a_i(src_a), .src_b_i(src_b),
      .result_o(result), .dest_o(dest), .wr_en_o(wr_en), .overflow_o(ovf), .accepted_o(acc),
      .issue_break_o(brk), .solo_issue_o(solo));
   // Second core built for release 6: its idle must not break issue
   int_shift_subtract_alu #(.RELEASE6(1'b1)) i_dut_r6 (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .issue_valid_i(issue_valid), .instr_i(instr), .src_a_i(src_a), .src_b_i(src_b),
      .result_o(), .dest_o(), .wr_en_o(), .overflow_o(), .accepted_o(acc6),
      .issue_break_o(brk6), .solo_issue_o(solo6));
   // ************************************************************
   // Helpers and scenarios
   // ************************************************************
   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   function automatic logic [31:0] enc(logic [4:0] fa, fb, fd, amt, logic [5:0] fn);
      return {OPC_SPECIAL, fa, fb, fd, amt, fn};
   endfunction
   task automatic run(logic [31:0] w, logic [31:0] a, logic [31:0] b);
      @(posedge ref_clk_i);
      req <= 1'b1; word <= w; a_w <= a; b_w <= b;
      @(posedge ref_clk_i);
      req <= 1'b0;
      #1;
   endtask
   task automatic t_shifts;
      run(enc(5'h01, 5'h02, 5'h03, 5'h00, FN_RIGHT_ARITH_VAR), 32'hFFFFFFE4, 32'h80000F00);
      `CHK(result, 64'hFFFFFFFFF80000F0)
      `CHK({acc, wr_en, dest}, 7'h63)
      run(enc(5'h01, 5'h02, 5'h04, 5'h00, FN_RIGHT_LOGICAL_VAR), 32'hFFFFFFFF, 32'h80000F00);
      `CHK(result, 64'h0000000000000001)
      `CHK(dest, 5'h04)
      run(enc(5'h01, 5'h02, 5'h05, 5'h00, FN_RIGHT_LOGICAL_VAR), 32'h00000004, 32'h80000F00);
      `CHK(result, 64'h00000000080000F0)
      run(enc(5'h00, 5'h02, 5'h06, 5'h01, FN_RIGHT_LOGICAL_FIXED), 32'h0, 32'hFFFFFFFE);
      `CHK(result, 64'h000000007FFFFFFF)
   endtask
   task automatic t_sub;
      run(enc(5'h01, 5'h02, 5'h07, 5'h00, FN_MINUS_TRAP), 32'h00000005, 32'h00000007);
      `CHK(result, 64'hFFFFFFFFFFFFFFFE)
      `CHK({wr_en, ovf}, 2'b10)
      run(enc(5'h01, 5'h02, 5'h08, 5'h00, FN_MINUS_TRAP), 32'h80000000, 32'h00000001);
      `CHK({acc, wr_en, ovf}, 3'b101)
      `CHK(result, 64'hFFFFFFFFFFFFFFFE)
      `CHK(dest, 5'h08)
      run(enc(5'h01, 5'h02, 5'h09, 5'h00, FN_MINUS_WRAP), 32'h80000000, 32'h00000001);
      `CHK({wr_en, ovf}, 2'b10)
      `CHK(result, 64'h000000007FFFFFFF)
   endtask
   task automatic t_idle;
      @(posedge ref_clk_i);
      req <= 1'b1; word <= 32'h00000040; a_w <= 32'h0; b_w <= 32'h00000005;
      @(posedge ref_clk_i);
      word <= enc(5'h01, 5'h02, 5'h0A, 5'h00, FN_RIGHT_ARITH_VAR);
      #1;
      `CHK({acc, brk, solo}, 3'b111)
      `CHK(wr_en, 1'b0)
      `CHK({acc6, brk6, solo6}, 3'b100)
      @(posedge ref_clk_i);
      req <= 1'b0;
      #1;
      `CHK({acc, wr_en, brk}, 3'b110)
      `CHK(result, 64'h0000000000000005)
   endtask
   task automatic t_refuse;
      run(enc(5'h01, 5'h02, 5'h0B, 5'h01, FN_RIGHT_ARITH_VAR), 32'h1, 32'h2);
      `CHK({acc, wr_en}, 2'b00)
      run(enc(5'h01, 5'h02, 5'h0B, 5'h01, FN_RIGHT_LOGICAL_VAR), 32'h1, 32'h2);
      `CHK({acc, wr_en}, 2'b00)
      run(enc(5'h01, 5'h02, 5'h0B, 5'h01, FN_RIGHT_LOGICAL_FIXED), 32'h1, 32'h2);
      `CHK({acc, wr_en}, 2'b00)
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      t_shifts();
      t_sub();
      t_idle();
      t_refuse();
      wrap_up();
   end
   // Scenarios need well under a hundred cycles
   initial begin
      #40000;
      err_total++;
      wrap_up();
   end
endmodule
